// ### rtl/usb_ep_consts.svh
`ifndef USB_EP_CONSTS_SVH
`define USB_EP_CONSTS_SVH

// ----------------------------------------------------------------
// register indices on the byte port
// ----------------------------------------------------------------
`define OFF_EP0 4'h0
`define OFF_EP1 4'h1
`define OFF_EP5 4'h5
`define OFF_CTL 4'h6
`define OFF_STAT 4'h7
`define OFF_MASK 4'h8

// ----------------------------------------------------------------
// endpoint 0 control fields
// ----------------------------------------------------------------
`define EP0_DONE 7
`define EP0_TXTOG 6
`define EP0_TXST_HI 5
`define EP0_TXST_LO 4
`define EP0_RSVD 3
`define EP0_RXTOG 2
`define EP0_RXST_HI 1
`define EP0_RXST_LO 0

// ----------------------------------------------------------------
// endpoint 1..5 transmit control fields
// ----------------------------------------------------------------
`define EPT_DONE 3
`define EPT_TOG 2
`define EPT_ST_HI 1
`define EPT_ST_LO 0

// ----------------------------------------------------------------
// other fields
// ----------------------------------------------------------------
`define CTL_FORCE_RST 0
`define MASK_XFER 7
`define ATTN_HI 2

// ----------------------------------------------------------------
// handshake state codes and reset values
// ----------------------------------------------------------------
`define ST_DISABLED 2'h0
`define ST_STALL 2'h1
`define ST_NAK 2'h2
`define ST_VALID 2'h3
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_ATTN 3'h0
`define NUM_TX_EP 5
`define LAST_EP 3'h5

`endif

// ### rtl/usb_ep_ctrl.sv
// Behaviour
// - ep0 done flag set on good transfer
// - usb reset clears ep0 toggles and states
// - setup token forces ep0 tx toggle one
// - tx toggle picks pid, flips on ack
// - software may write toggles directly
// - ep0 tx state: off, stall, nak, valid
// - ep0 rx state: off, stall, nak, valid
// - ep0 good transfer sets both states nak
// - setup stage clears ep0 rx toggle
// - rx toggle flips on matching good data
// - setup on enabled ep0 acked, both nak
// - ep0 stall answer sets both states stall
// - ep0 bit 3 always reads zero
// - tx registers upper nibble reads zero
// - usb reset clears tx toggles and states
// - tx done flag set on good transmission
// - tx state: off, stall, nak, valid
// - tx good transfer sets state nak
// - irq needs mask set, global disable clear
// - done endpoint number recorded in status
`timescale 1ns/1ps
`include "usb_ep_consts.svh"

module usb_ep_ctrl (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  // register port
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  // packet engine events
  input wire usb_ep_pkg::ev_t I_EVENT,
  input wire logic I_BUS_RESET,
  // token handshake query
  input wire usb_ep_pkg::tok_t I_TOKEN,
  output usb_ep_pkg::answer_t O_ANSWER,
  output logic O_TX_DATA1,
  // interrupt request and reset state
  input wire logic I_GLOBAL_IRQ_DIS,
  output logic O_XFER_IRQ,
  output logic O_USB_RESET_ACTIVE
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic usb_ep_pkg::answer_t state_answer(input logic [1:0] st);
    usb_ep_pkg::answer_t a;
    a = usb_ep_pkg::ANS_IGNORE;
    case (st)
      `ST_STALL: a = usb_ep_pkg::ANS_STALL;
      `ST_NAK: a = usb_ep_pkg::ANS_NAK;
      `ST_VALID: a = usb_ep_pkg::ANS_HANDLE;
      default: a = usb_ep_pkg::ANS_IGNORE;
    endcase
    return a;
  endfunction

  function automatic logic is_tx_ep(input logic [2:0] ep);
    return (ep != 3'h0) && (ep <= `LAST_EP);
  endfunction

  // endpoint 1..5 to array slot 0..4
  function automatic logic [2:0] tx_slot(input logic [2:0] ep);
    return ep - 3'h1;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  usb_ep_pkg::state_t s_r;
  usb_ep_pkg::state_t s_nxt;
  logic usb_rst;
  logic any_done;
  logic [2:0] wslot;
  logic [2:0] eslot;
  logic [2:0] tslot;

  assign usb_rst = I_BUS_RESET | s_r.force_rst;
  assign wslot = tx_slot(I_REG_ADDR[2:0]);
  assign eslot = tx_slot(I_EVENT.ep);
  assign tslot = tx_slot(I_TOKEN.ep);

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = `RST_BYTE;

    // ----------------------------------------------------------------
    // register read, answered next cycle
    // ----------------------------------------------------------------
    if (I_REG_RD)
    begin
      if (I_REG_ADDR == `OFF_EP0)
      begin
        s_nxt.rdata = s_r.ep0;
        s_nxt.rdata[`EP0_RSVD] = 1'b0;
      end
      else if (I_REG_ADDR >= `OFF_EP1 && I_REG_ADDR <= `OFF_EP5)
      begin
        s_nxt.rdata = {`RST_NIBBLE, s_r.ept[wslot]};
      end
      else if (I_REG_ADDR == `OFF_CTL)
      begin
        s_nxt.rdata[`CTL_FORCE_RST] = s_r.force_rst;
      end
      else if (I_REG_ADDR == `OFF_STAT)
      begin
        s_nxt.rdata[`ATTN_HI:0] = s_r.attn;
      end
      else if (I_REG_ADDR == `OFF_MASK)
      begin
        s_nxt.rdata[`MASK_XFER] = s_r.mask;
      end
    end

    // ----------------------------------------------------------------
    // register write
    // ----------------------------------------------------------------
    if (I_REG_WR)
    begin
      if (I_REG_ADDR == `OFF_EP0)
      begin
        s_nxt.ep0[`EP0_DONE] = s_r.ep0[`EP0_DONE] & I_REG_WDATA[`EP0_DONE];
        s_nxt.ep0[`EP0_TXTOG] = I_REG_WDATA[`EP0_TXTOG];
        s_nxt.ep0[`EP0_TXST_HI:`EP0_TXST_LO] = I_REG_WDATA[`EP0_TXST_HI:`EP0_TXST_LO];
        s_nxt.ep0[`EP0_RSVD] = 1'b0;
        s_nxt.ep0[`EP0_RXTOG] = I_REG_WDATA[`EP0_RXTOG];
        s_nxt.ep0[`EP0_RXST_HI:`EP0_RXST_LO] = I_REG_WDATA[`EP0_RXST_HI:`EP0_RXST_LO];
      end
      else if (I_REG_ADDR >= `OFF_EP1 && I_REG_ADDR <= `OFF_EP5)
      begin
        s_nxt.ept[wslot][`EPT_DONE] = s_r.ept[wslot][`EPT_DONE]
                                      & I_REG_WDATA[`EPT_DONE];
        s_nxt.ept[wslot][`EPT_TOG] = I_REG_WDATA[`EPT_TOG];
        s_nxt.ept[wslot][`EPT_ST_HI:`EPT_ST_LO] = I_REG_WDATA[`EPT_ST_HI:`EPT_ST_LO];
      end
      else if (I_REG_ADDR == `OFF_CTL)
      begin
        s_nxt.force_rst = I_REG_WDATA[`CTL_FORCE_RST];
      end
      else if (I_REG_ADDR == `OFF_MASK)
      begin
        s_nxt.mask = I_REG_WDATA[`MASK_XFER];
      end
    end

    // ----------------------------------------------------------------
    // link events, applied after the write so they win
    // ----------------------------------------------------------------
    if (I_EVENT.valid && !usb_rst)
    begin
      if (I_EVENT.ep == 3'h0)
      begin
        case (I_EVENT.kind)
          usb_ep_pkg::EV_SETUP:
          begin
            // disabled endpoint ignores the setup entirely
            if (s_r.ep0[`EP0_RXST_HI:`EP0_RXST_LO] != `ST_DISABLED)
            begin
              s_nxt.ep0[`EP0_TXTOG] = 1'b1;
              s_nxt.ep0[`EP0_RXTOG] = 1'b0;
              s_nxt.ep0[`EP0_TXST_HI:`EP0_TXST_LO] = `ST_NAK;
              s_nxt.ep0[`EP0_RXST_HI:`EP0_RXST_LO] = `ST_NAK;
              s_nxt.ep0[`EP0_DONE] = 1'b1;
              s_nxt.attn = 3'h0;
            end
          end
          usb_ep_pkg::EV_TX_ACK:
          begin
            if (s_r.ep0[`EP0_TXST_HI:`EP0_TXST_LO] == `ST_VALID)
            begin
              s_nxt.ep0[`EP0_TXTOG] = ~s_r.ep0[`EP0_TXTOG];
              s_nxt.ep0[`EP0_TXST_HI:`EP0_TXST_LO] = `ST_NAK;
              s_nxt.ep0[`EP0_RXST_HI:`EP0_RXST_LO] = `ST_NAK;
              s_nxt.ep0[`EP0_DONE] = 1'b1;
              s_nxt.attn = 3'h0;
            end
          end
          usb_ep_pkg::EV_RX_OK:
          begin
            // a repeated packet with the old pid is not a new transfer
            if (s_r.ep0[`EP0_RXST_HI:`EP0_RXST_LO] == `ST_VALID
                && I_EVENT.data_pid1 == s_r.ep0[`EP0_RXTOG])
            begin
              s_nxt.ep0[`EP0_RXTOG] = ~s_r.ep0[`EP0_RXTOG];
              s_nxt.ep0[`EP0_TXST_HI:`EP0_TXST_LO] = `ST_NAK;
              s_nxt.ep0[`EP0_RXST_HI:`EP0_RXST_LO] = `ST_NAK;
              s_nxt.ep0[`EP0_DONE] = 1'b1;
              s_nxt.attn = 3'h0;
            end
          end
          default:
          begin
            s_nxt.ep0[`EP0_TXST_HI:`EP0_TXST_LO] = `ST_STALL;
            s_nxt.ep0[`EP0_RXST_HI:`EP0_RXST_LO] = `ST_STALL;
          end
        endcase
      end
      else if (is_tx_ep(I_EVENT.ep))
      begin
        if (I_EVENT.kind == usb_ep_pkg::EV_TX_ACK
            && s_r.ept[eslot][`EPT_ST_HI:`EPT_ST_LO] == `ST_VALID)
        begin
          s_nxt.ept[eslot][`EPT_TOG] = ~s_r.ept[eslot][`EPT_TOG];
          s_nxt.ept[eslot][`EPT_ST_HI:`EPT_ST_LO] = `ST_NAK;
          s_nxt.ept[eslot][`EPT_DONE] = 1'b1;
          s_nxt.attn = I_EVENT.ep;
        end
      end
    end

    // ----------------------------------------------------------------
    // usb reset, received or forced; done flags survive it
    // ----------------------------------------------------------------
    if (usb_rst)
    begin
      s_nxt.ep0[`EP0_TXTOG:`EP0_TXST_LO] = 3'h0;
      s_nxt.ep0[`EP0_RXTOG:`EP0_RXST_LO] = 3'h0;
      for (int i = 0; i < `NUM_TX_EP; i++)
      begin
        s_nxt.ept[i][`EPT_TOG:`EPT_ST_LO] = 3'h0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      s_r.ep0 <= `RST_BYTE;
      s_r.ept <= '0;
      s_r.force_rst <= 1'b0;
      s_r.mask <= 1'b0;
      s_r.attn <= `RST_ATTN;
      s_r.rdata <= `RST_BYTE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // token handshake decision
  // ----------------------------------------------------------------
  always_comb
  begin
    O_ANSWER = usb_ep_pkg::ANS_IGNORE;
    O_TX_DATA1 = 1'b0;
    if (I_TOKEN.valid && !usb_rst)
    begin
      if (I_TOKEN.ep == 3'h0)
      begin
        case (I_TOKEN.kind)
          usb_ep_pkg::TOK_IN:
          begin
            O_ANSWER = state_answer(s_r.ep0[`EP0_TXST_HI:`EP0_TXST_LO]);
            O_TX_DATA1 = s_r.ep0[`EP0_TXTOG];
          end
          usb_ep_pkg::TOK_OUT:
          begin
            O_ANSWER = state_answer(s_r.ep0[`EP0_RXST_HI:`EP0_RXST_LO]);
          end
          usb_ep_pkg::TOK_SETUP:
          begin
            if (s_r.ep0[`EP0_RXST_HI:`EP0_RXST_LO] != `ST_DISABLED)
            begin
              O_ANSWER = usb_ep_pkg::ANS_HANDLE;
            end
          end
          default:
          begin
            O_ANSWER = usb_ep_pkg::ANS_IGNORE;
          end
        endcase
      end
      else if (is_tx_ep(I_TOKEN.ep) && I_TOKEN.kind == usb_ep_pkg::TOK_IN)
      begin
        O_ANSWER = state_answer(s_r.ept[tslot][`EPT_ST_HI:`EPT_ST_LO]);
        O_TX_DATA1 = s_r.ept[tslot][`EPT_TOG];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    any_done = s_r.ep0[`EP0_DONE];
    for (int i = 0; i < `NUM_TX_EP; i++)
    begin
      any_done = any_done | s_r.ept[i][`EPT_DONE];
    end
  end

  assign O_XFER_IRQ = any_done & s_r.mask & ~I_GLOBAL_IRQ_DIS;
  assign O_REG_RDATA = s_r.rdata;
  assign O_USB_RESET_ACTIVE = usb_rst;

endmodule

// ### rtl/usb_ep_pkg.sv
package usb_ep_pkg;

  // ----------------------------------------------------------------
  // link events and token queries
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EV_SETUP,
    EV_TX_ACK,
    EV_RX_OK,
    EV_STALL_SENT
  } ev_kind_t;

  typedef struct packed {
    logic valid;
    logic [2:0] ep;
    ev_kind_t kind;
    logic data_pid1;
  } ev_t;

  typedef enum logic [1:0] {
    TOK_OUT,
    TOK_IN,
    TOK_SETUP
  } tok_kind_t;

  typedef struct packed {
    logic valid;
    logic [2:0] ep;
    tok_kind_t kind;
  } tok_t;

  typedef enum logic [1:0] {
    ANS_IGNORE,
    ANS_STALL,
    ANS_NAK,
    ANS_HANDLE
  } answer_t;

  // ----------------------------------------------------------------
  // whole block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ep0;
    logic [4:0][3:0] ept;
    logic force_rst;
    logic mask;
    logic [2:0] attn;
    logic [7:0] rdata;
  } state_t;

endpackage

// ### test/usb_ep_chk.sv
`timescale 1ns/1ps
module usb_ep_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] O_REG_RDATA,
  input wire usb_ep_pkg::ev_t I_EVENT,
  input wire logic I_BUS_RESET,
  input wire usb_ep_pkg::tok_t I_TOKEN,
  input wire usb_ep_pkg::answer_t O_ANSWER,
  input wire logic O_TX_DATA1,
  input wire logic I_GLOBAL_IRQ_DIS,
  input wire logic O_XFER_IRQ,
  input wire logic O_USB_RESET_ACTIVE
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  wire ev_ok = I_EVENT.valid && !O_USB_RESET_ACTIVE;
  wire in0 = I_TOKEN.valid && I_TOKEN.ep == 3'h0 && I_TOKEN.kind == usb_ep_pkg::TOK_IN;
  property p_rsvd;
    $past(I_REG_RD) && $past(I_REG_ADDR) == 4'h0 |-> !O_REG_RDATA[3];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("ep0 bit 3 read as one");
  property p_tx_hi;
    $past(I_REG_RD) && $past(I_REG_ADDR) inside {[4'h1:4'h5]} |-> O_REG_RDATA[7:4] == 4'h0;
  endproperty
  a_tx_hi: assert property (p_tx_hi) else $error("tx upper nibble set");
  property p_setup;
    ev_ok && I_EVENT.ep == 3'h0 && I_EVENT.kind == usb_ep_pkg::EV_SETUP && I_TOKEN.valid
      && I_TOKEN.kind == usb_ep_pkg::TOK_SETUP && O_ANSWER == usb_ep_pkg::ANS_HANDLE
      ##1 in0 && !O_USB_RESET_ACTIVE |-> O_ANSWER == usb_ep_pkg::ANS_NAK && O_TX_DATA1;
  endproperty
  a_setup: assert property (p_setup) else $error("setup left bad ep0 state");
  property p_stall;
    ev_ok && I_EVENT.ep == 3'h0 && I_EVENT.kind == usb_ep_pkg::EV_STALL_SENT
      ##1 in0 && !O_USB_RESET_ACTIVE |-> O_ANSWER == usb_ep_pkg::ANS_STALL;
  endproperty
  a_stall: assert property (p_stall) else $error("ep0 not stalled");
  property p_rst;
    O_USB_RESET_ACTIVE |=> O_ANSWER == usb_ep_pkg::ANS_IGNORE && !O_TX_DATA1;
  endproperty
  a_rst: assert property (p_rst) else $error("state kept over usb reset");
  property p_bus_rst;
    I_BUS_RESET |-> O_USB_RESET_ACTIVE;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus reset not active");
  property p_irq;
    I_GLOBAL_IRQ_DIS |-> !O_XFER_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
  property p_ack;
    ev_ok && I_EVENT.kind == usb_ep_pkg::EV_TX_ACK && I_TOKEN.valid
      && I_TOKEN.kind == usb_ep_pkg::TOK_IN && I_TOKEN.ep == I_EVENT.ep
      && O_ANSWER == usb_ep_pkg::ANS_HANDLE ##1 $stable(I_TOKEN) && !O_USB_RESET_ACTIVE
      |-> O_ANSWER == usb_ep_pkg::ANS_NAK && O_TX_DATA1 != $past(O_TX_DATA1);
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not flip or nak");
endmodule

bind usb_ep_ctrl usb_ep_chk usb_ep_chk_i (.*);

// ### test/usb_ep_ctrl_test.sv
`timescale 1ns/1ps
module usb_ep_ctrl_test;
  logic clk, rst, wr, rd, gdis, brst, d1, irq, ract;
  logic [3:0] addr;
  logic [7:0] wd, rdata, o, r;
  logic [7:0] m [0:5];
  usb_ep_pkg::ev_t ev;
  usb_ep_pkg::tok_t tok;
  usb_ep_pkg::answer_t ans;
  int n_fail, samples_checked, a;

  usb_ep_ctrl usb_ep_ctrl_i (.I_SYS_CLK(clk), .I_RESET(rst), .I_REG_ADDR(addr),
    .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_EVENT(ev),
    .I_BUS_RESET(brst), .I_TOKEN(tok), .O_ANSWER(ans), .O_TX_DATA1(d1),
    .I_GLOBAL_IRQ_DIS(gdis), .O_XFER_IRQ(irq), .O_USB_RESET_ACTIVE(ract));
  usb_host_model usb_host_model_i (.i_clk(clk), .o_ev(ev), .o_tok(tok), .o_bus_rst(brst));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----
  // expected register after a software write
  // ----
  function automatic logic [7:0] nx(input int a, input logic [7:0] p, d);
    return a == 0 ? {p[7] & d[7], d[6:4], 1'b0, d[2:0]} : {4'h0, p[3] & d[3], d[2:0]};
  endfunction
  task automatic chk(input string s, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wrr(input int a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a[3:0];
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 6) m[a] = nx(a, m[a], d);
  endtask
  task automatic rdc(input int a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a[3:0];
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic ans_c(input int e, input logic [1:0] k, x);
    usb_host_model_i.tok(e[2:0], k);
    #1 chk("answer", {6'h00, x}, 8'(ans));
  endtask
  task automatic ack(input int k);
    r = $urandom;
    wrr(k, k == 0 ? {1'b0, r[6], 2'b11, 1'b0, r[2:0]} : {5'h00, r[2], 2'b11});
    o = m[k];
    usb_host_model_i.tok(k[2:0], 2'h1);
    usb_host_model_i.ev(k[2:0], 2'h1, 1'b0, $urandom_range(2));
    #1 chk("data1", {7'h00, ~o[k == 0 ? 6 : 2]}, {7'h00, d1});
    m[k] = k == 0 ? {1'b1, ~o[6], 2'b10, 1'b0, o[2], 2'b10} : {5'h01, ~o[2], 2'b10};
    rdc(k, m[k]);
    rdc(7, k[7:0]);
    chk("irq", 8'h01, {7'h00, irq});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wd = 8'h00;
    gdis = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    foreach (m[i]) m[i] = 8'h00;
    void'($urandom(70664));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) rdc(i, 8'h00);
    repeat (40)
    begin
      r = $urandom;
      a = $urandom_range(5);
      wrr(a, r);
      rdc(a, m[a]);
    end
    wrr(7, 8'hFF);
    wrr(9, 8'hFF);
    rdc(7, 8'h00);
    rdc(9, 8'h00);
    for (int e = 0; e < 6; e++)
      for (int s = 0; s < 4; s++)
      begin
        wrr(e, e == 0 ? {2'b00, s[1:0], 2'b00, s[1:0]} : {6'h00, s[1:0]});
        ans_c(e, 2'h1, s[1:0]);
        if (e == 0) ans_c(0, 2'h0, s[1:0]);
      end
    ans_c(3, 2'h0, 2'h0);
    wrr(8, 8'h80);
    for (int k = 0; k < 6; k++) ack(k);
    @(posedge clk);
    gdis <= 1'b1;
    @(posedge clk);
    #1 chk("irq", 8'h00, {7'h00, irq});
    @(posedge clk);
    gdis <= 1'b0;
    wrr(1, 8'h0B);
    o = m[1];
    fork
      wrr(1, {5'h00, o[2], 2'b11});
      usb_host_model_i.ev(3'h1, 2'h1, 1'b0, 0);
    join
    m[1] = {5'h01, ~o[2], 2'b10};
    rdc(1, m[1]);
    wrr(0, 8'h37);
    usb_host_model_i.tok(3'h0, 2'h2);
    usb_host_model_i.ev(3'h0, 2'h0, 1'b0, 0);
    usb_host_model_i.tok(3'h0, 2'h1);
    #1 chk("data1", 8'h01, {7'h00, d1});
    chk("answer", 8'h02, 8'(ans));
    rdc(0, 8'hE2);
    rdc(7, 8'h00);
    wrr(0, 8'h30);
    usb_host_model_i.ev(3'h0, 2'h0, 1'b0, 1);
    rdc(0, 8'h30);
    wrr(0, 8'h03);
    usb_host_model_i.ev(3'h0, 2'h2, 1'b1, 0);
    rdc(0, 8'h03);
    usb_host_model_i.ev(3'h0, 2'h2, 1'b0, 2);
    rdc(0, 8'hA6);
    usb_host_model_i.ev(3'h0, 2'h3, 1'b0, 0);
    #1 chk("answer", 8'h01, 8'(ans));
    rdc(0, 8'h95);
    m[0] = 8'h95;
    usb_host_model_i.bus_rst;
    #1 chk("answer", 8'h00, 8'(ans));
    for (int i = 0; i < 6; i++) rdc(i, m[i] & (i == 0 ? 8'h80 : 8'h08));
    wrr(6, 8'h01);
    #1 chk("reset_active", 8'h01, {7'h00, ract});
    wrr(6, 8'h00);
    rdc(6, 8'h00);
    chk("reset_active", 8'h00, {7'h00, ract});
    wrr(8, 8'h00);
    rdc(8, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    @(posedge clk);
    #1 chk("rdata", 8'h00, rdata);
    results;
  end
endmodule

// ### test/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  input wire logic i_clk,
  output usb_ep_pkg::ev_t o_ev,
  output usb_ep_pkg::tok_t o_tok,
  output logic o_bus_rst
);
  initial
  begin
    o_ev = '0;
    o_tok = '0;
    o_bus_rst = 1'b0;
  end
  // ----
  // one event after g idle cycles, fields scrambled once released
  // ----
  task automatic ev(input logic [2:0] e, input logic [1:0] k, input logic p, input int g);
    repeat (g) @(posedge i_clk);
    @(posedge i_clk);
    o_ev <= '{1'b1, e, usb_ep_pkg::ev_kind_t'(k), p};
    @(posedge i_clk);
    o_ev <= '{1'b0, ~e, usb_ep_pkg::ev_kind_t'(~k), ~p};
  endtask
  task automatic tok(input logic [2:0] e, input logic [1:0] k);
    o_tok <= '{1'b1, e, usb_ep_pkg::tok_kind_t'(k)};
  endtask
  task automatic bus_rst;
    @(posedge i_clk);
    o_bus_rst <= 1'b1;
    @(posedge i_clk);
    o_bus_rst <= 1'b0;
  endtask
endmodule
